/* File: verilog/phy_pkg.sv */
package phy_pkg;

  // Register addresses as seen with the bank input high.
  localparam logic [5:0] ADDR_INDICATOR_SELECT = 6'h20;
  localparam logic [5:0] ADDR_RX_ERROR_TALLY = 6'h21;
  localparam logic [5:0] ADDR_INTERRUPT_CONTROL = 6'h22;
  localparam logic [5:0] ADDR_INTERRUPT_FLAGS = 6'h23;

  // Field positions of the indicator source selectors.
  localparam int IND_ZERO_LSB = 0;
  localparam int IND_ONE_LSB = 3;
  localparam int IND_TWO_LSB = 6;
  localparam int IND_THREE_LSB = 9;
  localparam int SEL_BITS = 12;

  // Field positions of the interrupt control register.
  localparam int INTC_OUT_EN = 15;
  localparam int INTC_READ_CLR = 14;
  localparam int INTC_POLARITY = 13;
  localparam int INTC_AUTO_CLR = 12;
  localparam int NUM_SOURCES = 11;

  // Reset values and the interrupt control write mask.
  localparam logic [11:0] SEL_RESET = 12'hFE9;
  localparam logic [15:0] INTC_RESET = 16'h0000;
  localparam logic [15:0] TALLY_RESET = 16'h0000;
  localparam logic [15:0] INTC_WRITE_MASK = 16'hF7FF;

  // Indicator source codes.
  localparam logic [2:0] SRC_LINK = 3'h0;
  localparam logic [2:0] SRC_ACTIVITY = 3'h1;
  localparam logic [2:0] SRC_TX_DATA = 3'h2;
  localparam logic [2:0] SRC_RX_DATA = 3'h3;
  localparam logic [2:0] SRC_COLLISION = 3'h4;
  localparam logic [2:0] SRC_SPEED = 3'h5;
  localparam logic [2:0] SRC_DUPLEX = 3'h6;
  localparam logic [2:0] SRC_OFF = 3'h7;

  // Serial management frame constants.
  localparam logic [5:0] PREAMBLE_BITS = 6'h20;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [5:0] HDR_LAST = 6'h0C;
  localparam logic [5:0] DATA_LAST = 6'h11;

  typedef struct packed {
    logic link_ok;
    logic activity;
    logic tx_data;
    logic rx_data;
    logic collision;
    logic speed_100;
    logic full_duplex;
  } link_status_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [15:0] wdata;
  } mgmt_req_s;

endpackage

/* File: verilog/mgmt_serial_slave.sv */
`timescale 1ns/1ps
module mgmt_serial_slave (
  input wire logic clock,
  input wire logic nrst,
  input wire logic mdc,
  input wire logic mdio_in,
  input wire logic [4:0] station_addr,
  input wire logic bank_hi,
  input wire logic [15:0] rd_data,
  output logic mdio_out,
  output logic mdio_oe,
  output phy_pkg::mgmt_req_s req
);

  typedef enum logic [2:0] {S_PRE, S_HDR, S_TA, S_RD, S_WR} frame_state_e;

  frame_state_e state_r, state_nxt;
  logic mdc_r;
  logic [5:0] cnt_r, cnt_nxt;
  logic [12:0] hdr_r, hdr_nxt;
  logic [15:0] sh_r, sh_nxt;
  logic [16:0] tx_r, tx_nxt;
  logic oe_r, oe_nxt, out_r, out_nxt;
  phy_pkg::mgmt_req_s req_r, req_nxt;
  logic rise, fall;

  assign rise = mdc & ~mdc_r;
  assign fall = ~mdc & mdc_r;

  // Frame decoder; the management clock is sampled as a plain input.
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    hdr_nxt = hdr_r;
    sh_nxt = sh_r;
    tx_nxt = tx_r;
    oe_nxt = oe_r;
    out_nxt = out_r;
    req_nxt = req_r;
    req_nxt.wr = 1'b0;
    req_nxt.rd = 1'b0;
    // Read data is caught while the read strobe is out, before any clear.
    if (req_r.rd) begin
      tx_nxt = {1'b0, rd_data};
    end
    case (state_r)
      S_PRE: begin
        if (rise) begin
          if (mdio_in) begin
            if (cnt_r != phy_pkg::PREAMBLE_BITS) begin
              cnt_nxt = cnt_r + 6'h01;
            end
          end else if (cnt_r == phy_pkg::PREAMBLE_BITS) begin
            state_nxt = S_HDR;
            cnt_nxt = '0;
          end else begin
            cnt_nxt = '0;
          end
        end
      end
      S_HDR: begin
        if (rise) begin
          hdr_nxt = {hdr_r[11:0], mdio_in};
          cnt_nxt = cnt_r + 6'h01;
          if (cnt_r == phy_pkg::HDR_LAST) begin
            cnt_nxt = '0;
            state_nxt = S_PRE;
            req_nxt.addr = {bank_hi, hdr_nxt[4:0]};
            if (hdr_nxt[12] && hdr_nxt[9:5] == station_addr) begin
              if (hdr_nxt[11:10] == phy_pkg::OP_READ) begin
                req_nxt.rd = 1'b1;
                state_nxt = S_TA;
              end else if (hdr_nxt[11:10] == phy_pkg::OP_WRITE) begin
                state_nxt = S_WR;
              end
            end
          end
        end
      end
      S_TA: begin
        if (rise) begin
          state_nxt = S_RD;
        end
      end
      S_RD: begin
        // Turnaround zero, then sixteen data bits, driven on falling edges.
        if (fall) begin
          if (cnt_r == phy_pkg::DATA_LAST) begin
            oe_nxt = 1'b0;
            out_nxt = 1'b0;
            cnt_nxt = '0;
            state_nxt = S_PRE;
          end else begin
            oe_nxt = 1'b1;
            out_nxt = tx_r[16];
            tx_nxt = {tx_r[15:0], 1'b0};
            cnt_nxt = cnt_r + 6'h01;
          end
        end
      end
      S_WR: begin
        if (rise) begin
          sh_nxt = {sh_r[14:0], mdio_in};
          cnt_nxt = cnt_r + 6'h01;
          if (cnt_r == phy_pkg::DATA_LAST) begin
            req_nxt.wr = 1'b1;
            req_nxt.wdata = sh_nxt;
            cnt_nxt = '0;
            state_nxt = S_PRE;
          end
        end
      end
      default: begin
        state_nxt = S_PRE;
        cnt_nxt = '0;
      end
    endcase
  end

  // Frame state registers.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_r <= S_PRE;
      mdc_r <= 1'b0;
      cnt_r <= '0;
      hdr_r <= '0;
      sh_r <= '0;
      tx_r <= '0;
      oe_r <= 1'b0;
      out_r <= 1'b0;
      req_r <= '0;
    end else begin
      state_r <= state_nxt;
      mdc_r <= mdc;
      cnt_r <= cnt_nxt;
      hdr_r <= hdr_nxt;
      sh_r <= sh_nxt;
      tx_r <= tx_nxt;
      oe_r <= oe_nxt;
      out_r <= out_nxt;
      req_r <= req_nxt;
    end
  end

  assign mdio_out = out_r;
  assign mdio_oe = oe_r;
  assign req = req_r;

endmodule // mgmt_serial_slave

/* File: verilog/phy_led_irq_control.sv */
`timescale 1ns/1ps
// Operation
// - Indicator three source from selector, resets off.
// - Indicator two same codes, 111 off, resets off.
// - Indicator one selector resets to speed code.
// - Indicator zero resets activity; 111 shows link.
// - Sixteen-bit receive error tally, readable and writable.
// - Interrupt pin driven only when output enabled.
// - Read clears latched flags when read-clear set.
// - Auto-clear drops flag once cause goes away.
// - Per-source enables gate which flags raise interrupt.
// - Each source latches a read-only event flag.
module phy_led_irq_control #(
  parameter int NUM_SRC = phy_pkg::NUM_SOURCES,
  parameter int TALLY_W = 16
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [4:0] station_addr,
  input wire logic bank_hi,
  input wire phy_pkg::link_status_s link,
  input wire logic rmii_mode,
  input wire logic rx_error,
  input wire logic [NUM_SRC-1:0] event_cond,
  output logic indicator_zero,
  output logic indicator_one,
  output logic indicator_two,
  output logic indicator_three,
  output logic irq_out,
  output logic irq_oe
);

  // The flag and enable fields share bit positions and end below bit 11.
  if (NUM_SRC < 1 || NUM_SRC > 11 || TALLY_W < 1 || TALLY_W > 16) begin
    $error("Unsupported source count or tally width.");
  end

  phy_pkg::mgmt_req_s req;
  logic [15:0] rd_data;
  logic [phy_pkg::SEL_BITS-1:0] sel_r, sel_nxt;
  logic [15:0] intc_r, intc_nxt;
  logic [TALLY_W-1:0] tally_r, tally_nxt;
  logic [NUM_SRC-1:0] flag_r, flag_nxt, clr_mask, enables;
  logic [3:0] ind_r, ind_nxt;
  logic irq_r, irq_nxt, active;
  logic wr_sel, wr_intc, wr_tally, rd_flags;

  mgmt_serial_slave u_mgmt (
    .clock(clock),
    .nrst(nrst),
    .mdc(mdc),
    .mdio_in(mdio_in),
    .station_addr(station_addr),
    .bank_hi(bank_hi),
    .rd_data(rd_data),
    .mdio_out(mdio_out),
    .mdio_oe(mdio_oe),
    .req(req)
  );

  // One source code to one indicator level; the zero output maps 111 to link.
  function automatic logic pick(input logic [2:0] code,
                                input phy_pkg::link_status_s st,
                                input logic is_zero);
    case (code)
      phy_pkg::SRC_LINK: pick = st.link_ok;
      phy_pkg::SRC_ACTIVITY: pick = st.activity;
      phy_pkg::SRC_TX_DATA: pick = st.tx_data;
      phy_pkg::SRC_RX_DATA: pick = st.rx_data;
      phy_pkg::SRC_COLLISION: pick = st.collision;
      phy_pkg::SRC_SPEED: pick = st.speed_100;
      phy_pkg::SRC_DUPLEX: pick = st.full_duplex;
      default: pick = is_zero & st.link_ok;
    endcase
  endfunction

  // Register hits; a read of the flags only counts for a real read frame.
  assign wr_sel = req.wr && req.addr == phy_pkg::ADDR_INDICATOR_SELECT;
  assign wr_tally = req.wr && req.addr == phy_pkg::ADDR_RX_ERROR_TALLY;
  assign wr_intc = req.wr && req.addr == phy_pkg::ADDR_INTERRUPT_CONTROL;
  assign rd_flags = req.rd && req.addr == phy_pkg::ADDR_INTERRUPT_FLAGS;
  assign enables = intc_r[NUM_SRC-1:0];

  // Read multiplexer; unknown addresses and unused bits read as zero.
  always_comb begin
    rd_data = '0;
    case (req.addr)
      phy_pkg::ADDR_INDICATOR_SELECT: rd_data[phy_pkg::SEL_BITS-1:0] = sel_r;
      phy_pkg::ADDR_RX_ERROR_TALLY: rd_data[TALLY_W-1:0] = tally_r;
      phy_pkg::ADDR_INTERRUPT_CONTROL: rd_data = intc_r;
      phy_pkg::ADDR_INTERRUPT_FLAGS: rd_data[NUM_SRC-1:0] = flag_r;
      default: rd_data = '0;
    endcase
  end

  // Configuration registers and the error tally; a write beats a count.
  always_comb begin
    sel_nxt = sel_r;
    intc_nxt = intc_r;
    tally_nxt = tally_r;
    if (wr_sel) begin
      sel_nxt = req.wdata[phy_pkg::SEL_BITS-1:0];
    end
    if (wr_intc) begin
      intc_nxt = req.wdata & phy_pkg::INTC_WRITE_MASK;
    end
    if (wr_tally) begin
      tally_nxt = req.wdata[TALLY_W-1:0];
    end else if (rmii_mode && rx_error && tally_r != '1) begin
      tally_nxt = tally_r + 1'b1;
    end
  end

  // Flag latching; a cause present this cycle always wins over a clear.
  always_comb begin
    clr_mask = '0;
    if (rd_flags && intc_r[phy_pkg::INTC_READ_CLR]) begin
      clr_mask = '1;
    end
    if (intc_r[phy_pkg::INTC_AUTO_CLR]) begin
      clr_mask = clr_mask | ~event_cond;
    end
    flag_nxt = event_cond | (flag_r & ~clr_mask);
  end

  // Interrupt level and indicator outputs, registered to avoid glitches.
  always_comb begin
    active = |(flag_r & enables);
    irq_nxt = intc_r[phy_pkg::INTC_POLARITY] ? active : ~active;
    ind_nxt[0] = pick(sel_r[phy_pkg::IND_ZERO_LSB +: 3], link, 1'b1);
    ind_nxt[1] = pick(sel_r[phy_pkg::IND_ONE_LSB +: 3], link, 1'b0);
    ind_nxt[2] = pick(sel_r[phy_pkg::IND_TWO_LSB +: 3], link, 1'b0);
    ind_nxt[3] = pick(sel_r[phy_pkg::IND_THREE_LSB +: 3], link, 1'b0);
  end

  // State registers of the block.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sel_r <= phy_pkg::SEL_RESET;
      intc_r <= phy_pkg::INTC_RESET;
      tally_r <= phy_pkg::TALLY_RESET[TALLY_W-1:0];
      flag_r <= '0;
      ind_r <= '0;
      irq_r <= 1'b1;
    end else begin
      sel_r <= sel_nxt;
      intc_r <= intc_nxt;
      tally_r <= tally_nxt;
      flag_r <= flag_nxt;
      ind_r <= ind_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign indicator_zero = ind_r[0];
  assign indicator_one = ind_r[1];
  assign indicator_two = ind_r[2];
  assign indicator_three = ind_r[3];
  assign irq_out = irq_r;
  assign irq_oe = intc_r[phy_pkg::INTC_OUT_EN];

  // Checks on the behaviour above.
  a_oe_enable: assert property (@(posedge clock) disable iff (!nrst)
    wr_intc |=> irq_oe == $past(req.wdata[phy_pkg::INTC_OUT_EN]))
    else $error("Interrupt enable not followed.");
  a_off_reset: assert property (@(posedge clock)
    !nrst |=> indicator_three == 1'b0 && indicator_two == 1'b0)
    else $error("Indicator not off after reset.");
  a_one_speed: assert property (@(posedge clock) disable iff (!nrst)
    (sel_r[5:3] == phy_pkg::SRC_SPEED)
    |=> indicator_one == $past(link.speed_100))
    else $error("Indicator one not showing speed.");
  a_zero_link: assert property (@(posedge clock) disable iff (!nrst)
    (sel_r[2:0] == phy_pkg::SRC_OFF) |=> indicator_zero == $past(link.link_ok))
    else $error("Indicator zero code 111 not link.");
  a_tally_count: assert property (@(posedge clock) disable iff (!nrst)
    (rmii_mode && rx_error && !wr_tally && tally_r != '1)
    |=> tally_r == $past(tally_r) + 1'b1)
    else $error("Error tally did not count.");
  a_read_clear: assert property (@(posedge clock) disable iff (!nrst)
    (rd_flags && intc_r[phy_pkg::INTC_READ_CLR])
    |=> flag_r == $past(event_cond))
    else $error("Read did not clear flags.");
  a_flag_hold: assert property (@(posedge clock) disable iff (!nrst)
    (!intc_r[phy_pkg::INTC_AUTO_CLR]
     && !(rd_flags && intc_r[phy_pkg::INTC_READ_CLR]))
    |=> (flag_r & $past(flag_r)) == $past(flag_r))
    else $error("Flag lost without clear.");
  a_auto_clear: assert property (@(posedge clock) disable iff (!nrst)
    (intc_r[phy_pkg::INTC_AUTO_CLR] && !wr_intc)
    |=> flag_r == $past(event_cond))
    else $error("Auto clear mismatch.");
  a_irq_level: assert property (@(posedge clock) disable iff (!nrst)
    ((flag_r & enables) == '0 && !intc_r[phy_pkg::INTC_POLARITY])
    |=> irq_out == 1'b1)
    else $error("Interrupt asserted with no enabled flag.");
  a_irq_polar: assert property (@(posedge clock) disable iff (!nrst)
    ((flag_r & enables) != '0) |=> irq_out == $past(intc_r[13]))
    else $error("Interrupt level wrong polarity.");
  a_two_off: assert property (@(posedge clock) disable iff (!nrst)
    (sel_r[phy_pkg::IND_TWO_LSB +: 3] == phy_pkg::SRC_OFF)
    |=> indicator_two == 1'b0)
    else $error("Indicator two not off for code 111.");
  a_three_off: assert property (@(posedge clock) disable iff (!nrst)
    (sel_r[phy_pkg::IND_THREE_LSB +: 3] == phy_pkg::SRC_OFF)
    |=> indicator_three == 1'b0)
    else $error("Indicator three not off for code 111.");
  a_flag_set: assert property (@(posedge clock) disable iff (!nrst)
    (event_cond != '0)
    |=> (flag_r & $past(event_cond)) == $past(event_cond))
    else $error("Event not latched in flag.");
  a_tally_sat: assert property (@(posedge clock) disable iff (!nrst)
    (tally_r == '1 && !wr_tally) |=> tally_r == '1)
    else $error("Error tally wrapped past full.");

  // Cover points for the main scenarios.
  c_read_frame: cover property (@(posedge clock) disable iff (!nrst)
    req.rd ##[1:300] mdio_oe);
  c_irq_fires: cover property (@(posedge clock) disable iff (!nrst)
    irq_oe && irq_out == intc_r[phy_pkg::INTC_POLARITY]);
  c_tally_write: cover property (@(posedge clock) disable iff (!nrst)
    wr_tally);
  c_read_clear: cover property (@(posedge clock) disable iff (!nrst)
    rd_flags && intc_r[phy_pkg::INTC_READ_CLR]);
  c_auto_clear: cover property (@(posedge clock) disable iff (!nrst)
    intc_r[phy_pkg::INTC_AUTO_CLR] && flag_r != '0);

endmodule // phy_led_irq_control

/* File: bench/mgmt_host.sv */
`timescale 1ns/1ps
// Station management controller that frames reads and writes on the line.
module mgmt_host #(
  parameter int HALF = 4
) (
  input wire logic clock,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  output logic mdc,
  output logic mdio_in
);
  logic drv_r;
  logic bit_r;

  // The line has a pull-up, so it reads one while nobody drives it.
  assign mdio_in = mdio_oe ? mdio_out : (drv_r ? bit_r : 1'b1);

  // The clock stands low between frames.
  initial begin
    mdc = 1'b0;
    drv_r = 1'b0;
    bit_r = 1'b1;
  end

  // One bit; sampling late in the low phase lets the device's data settle.
  task automatic cycle(input logic drive, input logic b, output logic s);
    @(negedge clock);
    mdc = 1'b0;
    drv_r = drive;
    bit_r = b;
    repeat (HALF) @(negedge clock);
    s = mdio_in;
    mdc = 1'b1;
    repeat (HALF - 1) @(negedge clock);
  endtask

  // A whole frame, with a fresh preamble, since a refused one needs it.
  task automatic frame(input logic [4:0] phy, input logic [1:0] op,
                       input logic [4:0] reg_a, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [13:0] hdr;
    logic s;
    hdr = {2'b01, op, phy, reg_a};
    rd = 16'h0000;
    for (int i = 0; i < 32; i++) cycle(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) cycle(1'b1, hdr[i], s);
    if (op == phy_pkg::OP_WRITE) begin
      cycle(1'b1, 1'b1, s);
      cycle(1'b1, 1'b0, s);
      for (int i = 15; i >= 0; i--) cycle(1'b1, wd[i], s);
    end else begin
      cycle(1'b0, 1'b0, s);
      cycle(1'b0, 1'b0, s);
      for (int i = 15; i >= 0; i--) begin
        cycle(1'b0, 1'b0, s);
        rd[i] = s;
      end
    end
    @(negedge clock);
    mdc = 1'b0;
    drv_r = 1'b0;
    repeat (4) @(negedge clock);
  endtask
endmodule // mgmt_host

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  localparam logic [4:0] PHY = 5'h0B;
  localparam logic [5:0] SEL = phy_pkg::ADDR_INDICATOR_SELECT;
  localparam logic [5:0] CTL = phy_pkg::ADDR_INTERRUPT_CONTROL;
  logic clock, nrst, mdc, mdio_in, mdio_out, mdio_oe;
  logic rmii_mode, rx_error, irq_out, irq_oe;
  phy_pkg::link_status_s link;
  logic [10:0] event_cond;
  logic [3:0] ind;
  logic [31:0] seed, r;
  logic [15:0] en, ex;
  int mismatches, checks, t, n, ps;

  phy_led_irq_control uut (.clock(clock), .nrst(nrst), .mdc(mdc),
    .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .station_addr(PHY), .bank_hi(1'b1), .link(link),
    .rmii_mode(rmii_mode), .rx_error(rx_error), .event_cond(event_cond),
    .indicator_zero(ind[0]), .indicator_one(ind[1]),
    .indicator_two(ind[2]), .indicator_three(ind[3]),
    .irq_out(irq_out), .irq_oe(irq_oe));

  mgmt_host host (.clock(clock), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .mdc(mdc), .mdio_in(mdio_in));

  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Level an indicator should show for a selector code.
  function automatic logic ind_exp(input logic [2:0] c,
                                   input phy_pkg::link_status_s st,
                                   input logic zero);
    logic [7:0] v;
    v = {zero & st.link_ok, st.full_duplex, st.speed_100, st.collision,
         st.rx_data, st.tx_data, st.activity, st.link_ok};
    return v[c];
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got,
               exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    logic [15:0] x;
    host.frame(PHY, phy_pkg::OP_WRITE, a[4:0], d, x);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [15:0] e,
                        input string w);
    logic [15:0] x;
    host.frame(PHY, phy_pkg::OP_READ, a[4:0], 16'h0000, x);
    check(x, e, w);
  endtask

  // A one-cycle cause; three cycles cover flag and output registers.
  task automatic pulse(input int s);
    event_cond[s] = 1'b1;
    @(negedge clock);
    event_cond[s] = 1'b0;
    repeat (3) @(negedge clock);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Free-running system clock.
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Frames cost about 517 cycles each; this bound leaves ample margin.
  initial begin
    repeat (90000) @(posedge clock);
    mismatches++;
    $display("unexpected at %0t: run did not finish", $time);
    report_and_stop();
  end

  // Main sequence.
  initial begin
    nrst = 1'b0;
    rmii_mode = 1'b0;
    rx_error = 1'b0;
    event_cond = '0;
    mismatches = 0;
    checks = 0;
    seed = 32'h00000023;
    r = xorshift();
    link = r[6:0];
    repeat (8) @(negedge clock);
    nrst = 1'b1;
    repeat (2) @(negedge clock);
    ex = {14'h0000, link.speed_100, link.activity};
    check(16'(ind), ex, "reset ind");
    check(16'({irq_oe, irq_out}), 16'h0001, "reset irq");
    rd_chk(SEL, 16'h0FE9, "sel reset");
    rd_chk(phy_pkg::ADDR_RX_ERROR_TALLY, 16'h0000, "tally reset");
    rd_chk(CTL, 16'h0000, "ctrl reset");
    rd_chk(6'h24, 16'h0000, "unmapped");
    wr(phy_pkg::ADDR_INDICATOR_SELECT, 16'hFAC6);
    rd_chk(SEL, 16'h0AC6, "sel mix");
    // Every code on all four indicators, under several link states.
    for (int c = 0; c < 8; c++) begin
      wr(phy_pkg::ADDR_INDICATOR_SELECT, {4'h0, {4{c[2:0]}}});
      repeat (4) begin
        r = xorshift();
        link = r[6:0];
        repeat (2) @(negedge clock);
        for (int k = 0; k < 4; k++) begin
          ex = 16'(ind_exp(c[2:0], link, k == 0));
          check(16'(ind[k]), ex, "ind");
        end
      end
    end
    // Tally counts each high cycle, saturates, and stops outside the mode.
    rmii_mode = 1'b1;
    r = xorshift();
    n = int'(r[4:0]) + 1;
    rx_error = 1'b1;
    repeat (n) @(negedge clock);
    rx_error = 1'b0;
    rd_chk(phy_pkg::ADDR_RX_ERROR_TALLY, n[15:0], "tally");
    rmii_mode = 1'b0;
    rx_error = 1'b1;
    repeat (3) @(negedge clock);
    rx_error = 1'b0;
    rd_chk(phy_pkg::ADDR_RX_ERROR_TALLY, n[15:0], "tally idle");
    rmii_mode = 1'b1;
    wr(phy_pkg::ADDR_RX_ERROR_TALLY, 16'hFFFE);
    rx_error = 1'b1;
    repeat (3) @(negedge clock);
    rmii_mode = 1'b0;
    repeat (3) @(negedge clock);
    rx_error = 1'b0;
    rd_chk(phy_pkg::ADDR_RX_ERROR_TALLY, 16'hFFFF, "tally sat");
    // Each source: enable gating, latching, read without and with clear.
    for (int s = 0; s < 11; s++) begin
      t = (s + 1) % 11;
      en = 16'h0001 << s;
      ex = en | (16'h0001 << t);
      wr(phy_pkg::ADDR_INTERRUPT_CONTROL, 16'h8000 | en);
      pulse(t);
      check(16'({irq_oe, irq_out}), 16'h0003, "masked");
      pulse(s);
      check(16'({irq_oe, irq_out}), 16'h0002, "irq low");
      rd_chk(phy_pkg::ADDR_INTERRUPT_FLAGS, ex, "flags");
      rd_chk(phy_pkg::ADDR_INTERRUPT_FLAGS, ex, "flags kept");
      wr(phy_pkg::ADDR_INTERRUPT_CONTROL, 16'hC000 | en);
      rd_chk(phy_pkg::ADDR_INTERRUPT_FLAGS, ex, "pre clear");
      rd_chk(phy_pkg::ADDR_INTERRUPT_FLAGS, 16'h0000, "cleared");
      check(16'({irq_oe, irq_out}), 16'h0003, "irq idle");
    end
    // High polarity, then auto clear with the output disabled.
    r = xorshift();
    ps = int'(r[7:0]) % 11;
    en = 16'h0001 << ps;
    wr(phy_pkg::ADDR_INTERRUPT_CONTROL, 16'hA000 | en);
    check(16'(irq_out), 16'h0000, "high pol idle");
    pulse(ps);
    check(16'(irq_out), 16'h0001, "high pol set");
    wr(phy_pkg::ADDR_INTERRUPT_CONTROL, 16'h1000 | en);
    check(16'(irq_oe), 16'h0000, "oe off");
    rd_chk(phy_pkg::ADDR_INTERRUPT_FLAGS, 16'h0000, "auto clr");
    event_cond[ps] = 1'b1;
    rd_chk(phy_pkg::ADDR_INTERRUPT_FLAGS, en, "cause held");
    event_cond[ps] = 1'b0;
    rd_chk(phy_pkg::ADDR_INTERRUPT_FLAGS, 16'h0000, "cause gone");
    wr(phy_pkg::ADDR_INTERRUPT_CONTROL, 16'hFFFF);
    rd_chk(CTL, 16'hF7FF, "ctrl rw");
    host.frame(PHY ^ 5'h01, phy_pkg::OP_WRITE, 5'h02, 16'h0000, ex);
    rd_chk(phy_pkg::ADDR_INTERRUPT_CONTROL, 16'hF7FF, "foreign");
    report_and_stop();
  end
endmodule // tb_top
